// ==== hdl/branch_and_bit_set_exec.sv ====
// Phase-sequenced executor for the always-branch and bit set instructions
`timescale 1ns/1ps
`default_nettype none
module branch_and_bit_set_exec
  import branch_bit_pkg::*;
(
  input  wire logic              core_clk,
  input  wire logic              sys_rst,
  input  wire logic              instr_valid,
  input  wire logic [15:0]       instr_word,
  input  wire logic              ext_set_en,
  input  wire logic [3:0]        bank_pointer_register,
  input  wire logic [FADDR_W-1:0] index_base,
  input  wire logic [4:0]        status_in,
  output logic                   instr_ready,
  output logic [PC_W-1:0]        pc,
  output logic                   flush,
  output logic [4:0]             status_out,
  output logic [FADDR_W-1:0]     last_addr,
  output logic [DATA_W-1:0]      last_wdata,
  output logic                   reg_write
);
  typedef enum logic [1:0] {IDLE, JUMP_EXEC, JUMP_REFILL, SET_EXEC} op_t;
  typedef struct packed {
    phase_t              ph;
    op_t                 op;
    logic [15:0]         ir;
    logic [PC_W-1:0]     pc;
    logic [PC_W-1:0]     tgt;
    logic [FADDR_W-1:0]  addr;
    logic [DATA_W-1:0]   wdata;
    logic                wr;
    logic                flush;
    logic [4:0]          st;
  } state_t;
  state_t s_reg, s_next;
  logic [DATA_W-1:0] rd_data;
  logic              taken;

  // Decodes shared by the state logic and the checks
  function automatic logic is_rel_jump(input logic [15:0] w);
    return w[15:11] == JUMP_OP; // RULE_01
  endfunction
  function automatic logic is_bit_set(input logic [15:0] w);
    return w[15:12] == BIT_SET_OP; // RULE_05
  endfunction
  // Bank bit 0 selects access bank; extended mode reroutes low addresses
  function automatic logic [FADDR_W-1:0] faddr(input logic [15:0] w, input logic ext,
                                               input logic [3:0] bank, input logic [FADDR_W-1:0] base);
    logic [7:0] f;
    f = w[7:0];
    if (w[BANK_BIT]) begin
      faddr = {bank, f};
    end else if (ext && f <= ILO_LIMIT) begin
      faddr = base + FADDR_W'(f); // RULE_06
    end else if (f < ACCESS_SPLIT) begin
      faddr = {ACCESS_BANK_HI, f};
    end else begin
      faddr = {ACCESS_BANK_SFR, f};
    end
  endfunction

  // Offset sign-extended then doubled; base already holds PC+2
  logic [PC_W-1:0] ofs2;
  assign ofs2 = {{(PC_W-OFS_W-1){s_reg.ir[OFS_W-1]}}, s_reg.ir[OFS_W-1:0], 1'b0}; // RULE_02

  always_comb begin
    s_next = s_reg;
    s_next.ph = phase_t'(s_reg.ph + 2'd1);
    s_next.wr = 1'b0;
    s_next.flush = 1'b0; // Strobes default low, so each lasts one cycle
    case (s_reg.ph)
      Q1: begin
        // Refill cycle takes nothing; its strobe tells the fetch side
        if (s_reg.op == JUMP_REFILL) begin
          s_next.flush = 1'b1; // RULE_04
        end else if (instr_valid && is_rel_jump(instr_word)) begin
          s_next.op = JUMP_EXEC;
          s_next.ir = instr_word;
          s_next.pc = s_reg.pc + PC_STEP; // RULE_03
          s_next.flush = 1'b0;
        end else if (instr_valid && is_bit_set(instr_word)) begin
          s_next.op = SET_EXEC;
          s_next.ir = instr_word;
          s_next.pc = s_reg.pc + PC_STEP;
          s_next.addr = faddr(instr_word, ext_set_en, bank_pointer_register, index_base); // RULE_05
          s_next.flush = 1'b0;
        end else begin
          s_next.op = IDLE;
          s_next.flush = 1'b0;
          if (instr_valid) begin
            s_next.pc = s_reg.pc + PC_STEP;
          end
        end
      end
      Q2: begin
        if (s_reg.op == JUMP_EXEC) begin
          s_next.tgt = s_reg.pc + ofs2; // RULE_02
        end
      end
      Q3: begin
        if (s_reg.op == SET_EXEC) begin
          // Read data from memory lands now, one cycle after Q2 address
          s_next.wdata = rd_data | DATA_W'(1 << s_reg.ir[BIT_LSB +: BIT_IDX_W]); // RULE_05
          s_next.wr = 1'b1;
        end
      end
      Q4: begin
        if (s_reg.op == JUMP_EXEC) begin
          s_next.pc = s_reg.tgt; // RULE_04
          s_next.op = JUMP_REFILL;
        end else if (s_reg.op == JUMP_REFILL) begin
          s_next.op = IDLE;
        end else begin
          s_next.op = IDLE;
        end
        s_next.flush = 1'b0;
      end
      default: s_next.ph = Q1;
    endcase
    s_next.st = status_in; // RULE_07
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      // Phases restart at Q1, so a fetch is open right after release
      s_reg <= '{ph:    Q1,
                 op:    IDLE,
                 ir:    16'h0000,
                 pc:    PC_RESET,
                 tgt:   PC_RESET,
                 addr:  '0,
                 wdata: '0,
                 wr:    1'b0,
                 flush: 1'b0,
                 st:    5'h00};
    end else begin
      s_reg <= s_next;
    end
  end

  // Address stands from Q2, so the old byte is ready in Q3
  file_regs #(.AW(FADDR_W), .DW(DATA_W)) file_regs_i (
    .core_clk (core_clk),
    .wr_en    (s_reg.wr),
    .wr_addr  (s_reg.addr),
    .wr_data  (s_reg.wdata),
    .rd_addr  (s_reg.addr),
    .rd_data  (rd_data)
  );

  assign instr_ready = (s_reg.ph == Q1) && (s_reg.op != JUMP_REFILL);
  assign taken       = instr_ready && instr_valid;
  assign pc          = s_reg.pc;
  assign flush       = s_reg.flush;
  assign status_out  = s_reg.st;
  assign last_addr   = s_reg.addr;
  assign last_wdata  = s_reg.wdata;
  assign reg_write   = s_reg.wr;

  // One clock domain, so clocking and disable are shared
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  jump_decode_a: assert property ((taken && is_rel_jump(instr_word)) // RULE_01
    |=> s_reg.op == JUMP_EXEC)
    else $error("branch not decoded");
  jump_target_a: assert property ((taken && is_rel_jump(instr_word)) |-> ##4 // RULE_02
    (pc == $past(pc, 4) + PC_STEP + {{(PC_W-OFS_W-1){$past(instr_word[OFS_W-1], 4)}},
    $past(instr_word[OFS_W-1:0], 4), 1'b0}))
    else $error("branch target wrong");
  jump_base_a: assert property ((s_reg.op == JUMP_EXEC && s_reg.ph == Q2) // RULE_03
    |-> s_reg.pc == $past(s_reg.pc) + PC_STEP)
    else $error("branch base not advanced");
  pc_step_a: assert property ((taken && !is_rel_jump(instr_word)) // RULE_03
    |=> pc == $past(pc) + PC_STEP)
    else $error("pc not advanced by one word");
  jump_idle_a: assert property ((s_reg.op == JUMP_EXEC && s_reg.ph == Q4) // RULE_04
    |=> (!instr_ready && !reg_write)[*4])
    else $error("second branch cycle not idle");
  jump_flush_a: assert property ((s_reg.op == JUMP_EXEC && s_reg.ph == Q4) // RULE_04
    |-> ##2 flush)
    else $error("pipeline refill missing");
  flush_pulse_a: assert property (flush // RULE_04
    |=> !flush)
    else $error("refill strobe longer than a cycle");
  refill_end_a: assert property ((s_reg.op == JUMP_EXEC && s_reg.ph == Q4) // RULE_04
    |-> ##5 instr_ready)
    else $error("no fetch after refill");
  pc_hold_a: assert property ((s_reg.ph == Q2 || s_reg.ph == Q3) // RULE_04
    |=> $stable(pc))
    else $error("pc moved outside update");
  jump_no_write_a: assert property ((taken && is_rel_jump(instr_word)) // RULE_04
    |-> ##3 !reg_write)
    else $error("branch wrote a register");
  set_write_a: assert property ((taken && is_bit_set(instr_word)) // RULE_05
    |-> ##3 (reg_write && last_wdata[$past(instr_word[BIT_LSB +: BIT_IDX_W], 3)]))
    else $error("bit not set");
  set_bank_a: assert property ((taken && is_bit_set(instr_word) && instr_word[BANK_BIT]) // RULE_05
    |=> last_addr == {$past(bank_pointer_register), $past(instr_word[7:0])})
    else $error("banked addr wrong");
  set_single_a: assert property ((taken && is_bit_set(instr_word)) // RULE_05
    |-> ##4 instr_ready)
    else $error("bit set longer than one cycle");
  write_pulse_a: assert property (reg_write // RULE_05
    |=> !reg_write)
    else $error("write strobe longer than a cycle");
  set_indexed_a: assert property ((taken && is_bit_set(instr_word) && !instr_word[BANK_BIT] // RULE_06
    && ext_set_en && instr_word[7:0] <= ILO_LIMIT)
    |=> last_addr == $past(index_base) + FADDR_W'($past(instr_word[7:0])))
    else $error("indexed addr wrong");
  flags_kept_a: assert property (1 // RULE_07
    |=> status_out == $past(status_in))
    else $error("flags changed");

  // Main scenarios
  jump_cov_c: cover property (s_reg.op == JUMP_EXEC ##4 flush);
  backward_cov_c: cover property (taken && is_rel_jump(instr_word) && instr_word[OFS_W-1]);
  set_cov_c: cover property (reg_write);
  bank_cov_c: cover property (taken && is_bit_set(instr_word) && instr_word[BANK_BIT]);
  indexed_cov_c: cover property (taken && is_bit_set(instr_word) && ext_set_en && !instr_word[BANK_BIT]
    && instr_word[7:0] <= ILO_LIMIT);
endmodule // branch_and_bit_set_exec
`default_nettype wire

// ==== hdl/branch_bit_pkg.sv ====
// Constants and types for the relative branch and bit set executor
// Operation
// RULE_01: An opcode whose top five bits are 11010 is the always-branch, and its low eleven bits are a signed offset from -1024 to +1023.
// RULE_02: The always-branch doubles the signed offset and adds it to the program counter to form the new program counter.
// RULE_03: The addition starts from the counter already advanced past the branch, so the target is branch address plus 2 plus twice the offset.
// RULE_04: The always-branch takes two instruction cycles, writing the counter in phase four of the first and idling in the second.
// RULE_05: The bit set opcode 1000 bbba ffffffff forces bit b of the addressed register to one in one cycle, reading in phase two and writing in phase four.
// RULE_06: With bank bit zero and the extended set enabled, file addresses up to 95 are indexed literal offset accesses.
// RULE_07: Neither instruction changes any arithmetic status flag.
package branch_bit_pkg;
  localparam int PC_W          = 21;
  localparam int DATA_W        = 8;
  localparam int FADDR_W       = 12;
  localparam logic [4:0] JUMP_OP    = 5'h1A;
  localparam logic [3:0] BIT_SET_OP = 4'h8;
  localparam int OFS_W         = 11;
  localparam int BIT_LSB       = 9;
  localparam int BIT_IDX_W     = 3;
  localparam int BANK_BIT      = 8;
  localparam logic [7:0] ILO_LIMIT = 8'h5F;
  localparam logic [PC_W-1:0] PC_STEP = 21'h000002;
  localparam logic [PC_W-1:0] PC_RESET = 21'h000000;
  localparam logic [3:0] ACCESS_BANK_HI = 4'h0;
  localparam logic [3:0] ACCESS_BANK_SFR = 4'hF;
  localparam logic [7:0] ACCESS_SPLIT = 8'h60;
  typedef enum logic [1:0] {Q1, Q2, Q3, Q4} phase_t;
endpackage

// ==== hdl/file_regs.sv ====
// Small file register memory with registered read data
`timescale 1ns/1ps
`default_nettype none
module file_regs #(
  parameter int AW = 12,
  parameter int DW = 8
) (
  input  wire logic          core_clk,
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_addr,
  input  wire logic [DW-1:0] wr_data,
  input  wire logic [AW-1:0] rd_addr,
  output logic      [DW-1:0] rd_data
);
  logic [DW-1:0] mem [2**AW];
  always_ff @(posedge core_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule // file_regs
`default_nettype wire

// ==== sim/branch_and_bit_set_exec_bench.sv ====
// Self-checking bench for the always-branch and bit set executor
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, s) begin checked++; if ((s) !== (e)) begin n_mismatch++; $display("[ERR] %s exp %h got %h", nm, e, s); end end
module branch_and_bit_set_exec_bench;
  import branch_bit_pkg::*;
  typedef struct {bit br; logic [PC_W-1:0] pc; logic [FADDR_W-1:0] addr; logic [7:0] mask; logic [4:0] st;} note_t;
  logic                core_clk = 1'b0;
  logic                sys_rst  = 1'b1;
  logic                instr_valid = 1'b0;
  logic [15:0]         instr_word = 16'h0000;
  logic                ext_set_en = 1'b0;
  logic [3:0]          bank_pointer_register = 4'h0;
  logic [FADDR_W-1:0]  index_base = 12'h000;
  logic [4:0]          status_in = 5'h00;
  logic                instr_ready, flush, reg_write;
  logic [PC_W-1:0]     pc, epc;
  logic [4:0]          status_out;
  logic [FADDR_W-1:0]  last_addr;
  logic [DATA_W-1:0]   last_wdata;
  logic [31:0]         seed = 32'hB86C;
  logic [7:0]          known [logic [FADDR_W-1:0]];
  note_t               notes [$];
  int                  n_mismatch = 0, checked = 0, cycles = 0;
  always #2.5 core_clk = ~core_clk;
  branch_and_bit_set_exec branch_and_bit_set_exec_i (.core_clk(core_clk), .sys_rst(sys_rst),
    .instr_valid(instr_valid), .instr_word(instr_word), .ext_set_en(ext_set_en),
    .bank_pointer_register(bank_pointer_register), .index_base(index_base), .status_in(status_in),
    .instr_ready(instr_ready), .pc(pc), .flush(flush), .status_out(status_out), .last_addr(last_addr),
    .last_wdata(last_wdata), .reg_write(reg_write));
  function automatic logic [31:0] lfsr_next(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  // Offers one word, notes the expected result, walks the expected counter
  task automatic issue(input logic [15:0] w, input logic [FADDR_W-1:0] a, input logic [7:0] m);
    note_t n;
    while (instr_ready !== 1'b1) @(negedge core_clk);
    seed = lfsr_next(seed);
    status_in = seed[4:0];
    instr_word = w;
    instr_valid = 1'b1;
    n = '{w[15:11] == JUMP_OP, epc + 21'h2 + {{9{w[10]}}, w[10:0], 1'b0}, a, m, seed[4:0]};
    epc = (n.br) ? n.pc : epc + 21'h2;
    if (n.br || w[15:12] == BIT_SET_OP) notes.push_back(n);
    @(negedge core_clk);
    instr_valid = 1'b0;
  endtask
  task automatic bset(input logic [2:0] b, input logic a, input logic [7:0] f);
    logic [FADDR_W-1:0] ea;
    seed = lfsr_next(seed);
    ext_set_en = seed[8];
    bank_pointer_register = seed[12:9];
    index_base = seed[24:13];
    if (a) ea = {bank_pointer_register, f};
    else if (ext_set_en && f <= ILO_LIMIT) ea = index_base + {4'h0, f};
    else ea = {(f < ACCESS_SPLIT) ? ACCESS_BANK_HI : ACCESS_BANK_SFR, f};
    known[ea] = (known.exists(ea) ? known[ea] : 8'h00) | (8'h01 << b);
    issue({BIT_SET_OP, b, a, f}, ea, known[ea]);
  endtask
  // Results are matched in issue order against the oldest note
  always @(negedge core_clk) begin
    if (!sys_rst && (reg_write === 1'b1 || flush === 1'b1)) begin
      if (notes.size() == 0) begin
        n_mismatch++;
        $display("[ERR] result exp none got one");
      end else begin
        note_t n;
        n = notes.pop_front();
        `CHK("status", n.st, status_out)
        if (n.br) begin
          `CHK("flush kind", 1'b1, flush)
          `CHK("ready in refill", 1'b0, instr_ready)
          `CHK("pc", n.pc, pc)
        end else begin
          `CHK("addr", n.addr, last_addr)
          `CHK("data", n.mask, last_wdata & n.mask)
        end
      end
    end
  end
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Whole run needs about 330 cycles; generous ceiling
  always @(posedge core_clk) begin
    cycles++;
    if (cycles >= 6000) begin
      n_mismatch++;
      $display("[ERR] timeout exp done got hang");
      give_verdict();
    end
  end
  logic [10:0] ofs [6] = '{11'h000, 11'h001, 11'h7FF, 11'h3FF, 11'h400, 11'h155};
  initial begin
    epc = PC_RESET;
    repeat (10) @(negedge core_clk);
    sys_rst = 1'b0;
    `CHK("pc reset", PC_RESET, pc)
    foreach (ofs[i]) issue({JUMP_OP, ofs[i]}, 12'h000, 8'h00);
    seed = lfsr_next(seed);
    issue({JUMP_OP, seed[10:0]}, 12'h000, 8'h00);
    $display("test branch done");
    issue(16'hD800, 12'h000, 8'h00);
    issue(16'h0000, 12'h000, 8'h00);
    issue(16'hD010, 12'h000, 8'h00);
    $display("test refused opcode done");
    for (int b = 0; b < 8; b++) bset(b[2:0], 1'b1, 8'h3C);
    $display("test bit accumulate done");
    for (int k = 0; k < 40; k++) begin
      seed = lfsr_next(seed);
      bset(seed[2:0], seed[3], (k % 4 == 0) ? 8'h5F : (k % 4 == 1) ? 8'h60 : seed[31:24]);
      if (k % 8 == 7) issue({JUMP_OP, seed[30:20]}, 12'h000, 8'h00);
    end
    $display("test bit set mix done");
    repeat (12) @(negedge core_clk);
    `CHK("notes left", 0, notes.size())
    give_verdict();
  end
endmodule // branch_and_bit_set_exec_bench
`default_nettype wire
